/* dv/eeprom_host.sv */
// Host model of the three-wire link: frames, read-back and status polls
`default_nettype none

module eeprom_host (
  output var logic shift_clock,
  output var logic select,
  output var logic serial_data_in,
  input wire logic data_out,
  input wire logic data_out_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle link: clock parked low, device not selected
  initial begin
    shift_clock = 1'b0;
    select = 1'b0;
    serial_data_in = 1'b0;
  end

  // One link period, data changed while the clock is low
  task automatic tick(input logic d);
    serial_data_in <= d;
    #15 shift_clock <= 1'b1;
    #15 shift_clock <= 1'b0;
  endtask

  // Marker, opcode, address, optional data, then optional read-back
  task automatic frame(input logic [24:0] bits, input int n, input int nrd, output logic [16:0] rd,
                       output logic ok);
    rd = 17'h00000;
    // Start off the core clock's edge grid
    #7 select <= 1'b1;
    #20 ok = (data_out_oe_n === 1'b1);
    for (int i = n - 1; i >= 0; i--) tick(bits[i]);
    for (int i = 0; i < nrd; i++) begin
      rd = {rd[15:0], data_out};
      ok = ok && (data_out_oe_n === 1'b0);
      tick(~serial_data_in);
    end
    // One more clock: output must float after the last data bit
    if (nrd > 0) begin
      tick(~serial_data_in);
      ok = ok && (data_out_oe_n === 1'b1);
    end
    // Released data line shows no stale value
    serial_data_in <= ~serial_data_in;
    #20 select <= 1'b0;
    #20;
  endtask

  // Select low for the gap, then high to watch ready/busy
  task automatic poll(input int gap_ns, input int limit, output logic busy, output logic ready);
    select <= 1'b0;
    #(gap_ns) select <= 1'b1;
    #50 busy = (data_out_oe_n === 1'b0) && (data_out === 1'b0);
    ready = 1'b0;
    for (int i = 0; i < limit && !ready; i++) #10 ready = (data_out_oe_n === 1'b0) && (data_out === 1'b1);
    select <= 1'b0;
    #60;
  endtask

endmodule

`default_nettype wire

/* dv/test_three_wire_eeprom_command_port.sv */
// Self-checking bench of the EEPROM command port driven by the host model
`default_nettype none
`include "eeprom_regs.svh"
`define CHECK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module test_three_wire_eeprom_command_port;
  import eeprom_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PROG = 200;
  logic ref_clk, srst, shift_clock, select, serial_data_in, data_out, data_out_oe_n;
  logic [15:0] mem [64];
  logic [16:0] rd;
  logic ok, busy, ready;
  logic [5:0] a;
  logic [15:0] d;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  eeprom_port #(.PROG_CYCLES(PROG), .WORDS(64)) u_eeprom_port (.ref_clk(ref_clk), .srst(srst),
    .shift_clock(shift_clock), .select(select), .serial_data_in(serial_data_in), .data_out(data_out),
    .data_out_oe_n(data_out_oe_n));

  eeprom_host u_eeprom_host (.shift_clock(shift_clock), .select(select), .serial_data_in(serial_data_in),
    .data_out(data_out), .data_out_oe_n(data_out_oe_n));

  // --------------------------------------------------------------------------
  // Clock, timeout and verdict
  // --------------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  // --------------------------------------------------------------------------
  // Stimulus tasks
  // --------------------------------------------------------------------------
  task automatic do_reset(input int n);
    @(posedge ref_clk) srst <= 1'b1;
    repeat (n) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask

  // Programming frame; en says whether the device should accept it
  task automatic prog(input logic [1:0] op, input logic [5:0] aa, input logic [15:0] dd, input logic en);
    int n;
    n = (op == `OP_WRITE || (op == `OP_SPECIAL && aa[5:4] == `SUB_BULK_FILL)) ? 25 : 9;
    u_eeprom_host.frame(n == 25 ? {1'b1, op, aa, dd} : {16'h0000, 1'b1, op, aa}, n, 0, rd, ok);
    `CHECK("idle output", 1'b1, ok)
    if (op != `OP_SPECIAL || aa[5] != aa[4]) begin
      u_eeprom_host.poll(300, PROG + 50, busy, ready);
      `CHECK("busy status", en, busy)
      `CHECK("ready status", en, ready)
    end
    if (en) begin
      case (op)
        `OP_WRITE: mem[aa] = dd;
        `OP_ERASE: mem[aa] = `ERASED_WORD;
        default: for (int i = 0; i < 64; i++) if (aa[5] != aa[4]) mem[i] = aa[5] ? `ERASED_WORD : dd;
      endcase
    end
  endtask

  // Read one word and compare with the expected array
  task automatic rd_chk(input logic [5:0] aa);
    u_eeprom_host.frame({16'h0000, 1'b1, `OP_READ, aa}, 9, 17, rd, ok);
    `CHECK("read word", {1'b0, mem[aa]}, rd)
    `CHECK("read drive", 1'b1, ok)
    `CHECK("released", 1'b1, data_out_oe_n)
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    srst = 1'b1;
    void'($urandom(5));
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    // Refused at power-up, then enabled and erased
    prog(`OP_SPECIAL, 6'h2c, 16'h0000, 1'b0);
    prog(`OP_SPECIAL, 6'h3b, 16'h0000, 1'b1);
    prog(`OP_SPECIAL, 6'h25, 16'h0000, 1'b1);
    rd_chk(6'($urandom));
    // Writes at both address ends and random places
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($urandom);
      d = (i == 0) ? 16'h0000 : (i == 1) ? 16'h8001 : 16'($urandom);
      prog(`OP_WRITE, a, d, 1'b1);
      rd_chk(a);
    end
    prog(`OP_ERASE, a, 16'h0000, 1'b1);
    rd_chk(a);
    prog(`OP_SPECIAL, 6'h1e, 16'($urandom), 1'b1);
    rd_chk(6'h00);
    rd_chk(6'h3f);
    // Late select rise after the cycle ended shows nothing
    d = 16'($urandom);
    u_eeprom_host.frame({1'b1, `OP_WRITE, a, d}, 25, 0, rd, ok);
    mem[a] = d;
    u_eeprom_host.poll(PROG * 10 + 1000, 20, busy, ready);
    `CHECK("late status", 2'b00, {busy, ready})
    rd_chk(a);
    // Disable, then writes and erases are refused but reads work
    prog(`OP_SPECIAL, 6'h09, 16'h0000, 1'b1);
    prog(`OP_WRITE, a, ~d, 1'b0);
    prog(`OP_ERASE, a, 16'h0000, 1'b0);
    rd_chk(a);
    // Enabled state lost across a reset
    prog(`OP_SPECIAL, 6'h30, 16'h0000, 1'b1);
    do_reset(4);
    prog(`OP_WRITE, a, ~d, 1'b0);
    rd_chk(a);
    close_out();
  end

endmodule

`default_nettype wire

/* hw/eeprom_link.sv */
// Shift-clock side: frame receiver, read shifter, instruction hand-off
`default_nettype none
`include "eeprom_regs.svh"

module eeprom_link
  import eeprom_pkg::*;
(
  input wire logic shift_clock,
  input wire logic select,
  input wire logic serial_data_in,
  input wire logic srst,
  input wire logic [15:0] rd_word,
  output logic [5:0] rd_addr,
  output logic read_drive,
  output logic read_bit,
  output var cmd_type cmd,
  output logic cmd_toggle
);

  typedef enum {WAIT_START, HEADER, DATA, READ_OUT, DONE} link_phase_type;

  link_phase_type phase;
  logic [4:0] cnt;
  logic [7:0] hdr;
  logic [15:0] shreg;
  logic [7:0] next_hdr;
  cmd_kind_type next_kind;
  logic hdr_end;
  logic issue;

  // ----------------------------------------------------------------------------
  // Header decode
  // ----------------------------------------------------------------------------
  assign next_hdr = {hdr[6:0], serial_data_in};
  assign next_kind = decode_kind(next_hdr[7:6], next_hdr[5:0]);
  assign hdr_end = (phase == HEADER) && (cnt == `HDR_LAST);
  assign issue = (hdr_end && next_kind != KIND_READ && next_kind != KIND_WRITE && next_kind != KIND_BULK_FILL)
                 || (phase == DATA && cnt == `WORD_LAST);

  // Frame state, cleared whenever select is low
  always_ff @(posedge shift_clock or negedge select) begin
    if (!select) begin
      phase <= WAIT_START;
      cnt <= '0;
      hdr <= '0;
      shreg <= '0;
      read_drive <= 1'b0;
      read_bit <= 1'b0;
      rd_addr <= '0;
    end else begin
      case (phase)
        WAIT_START: begin
          if (serial_data_in) begin
            phase <= HEADER;
            cnt <= '0;
          end
        end
        HEADER: begin
          hdr <= next_hdr;
          cnt <= cnt + 5'h01;
          if (hdr_end) begin
            cnt <= '0;
            if (next_kind == KIND_READ) begin
              rd_addr <= next_hdr[5:0];
              read_drive <= 1'b1;
              read_bit <= 1'b0;
              phase <= READ_OUT;
            end else if (next_kind == KIND_WRITE || next_kind == KIND_BULK_FILL) begin
              phase <= DATA;
            end else begin
              phase <= DONE;
            end
          end
        end
        DATA: begin
          shreg <= {shreg[14:0], serial_data_in};
          cnt <= cnt + 5'h01;
          if (cnt == `WORD_LAST) begin
            phase <= DONE;
          end
        end
        READ_OUT: begin
          cnt <= cnt + 5'h01;
          if (cnt == '0) begin
            read_bit <= rd_word[15];
            shreg <= {rd_word[14:0], 1'b0};
          end else if (cnt == `WORD_BITS) begin
            read_drive <= 1'b0;
            read_bit <= 1'b0;
            phase <= DONE;
          end else begin
            read_bit <= shreg[15];
            shreg <= {shreg[14:0], 1'b0};
          end
        end
        DONE: begin
          cnt <= cnt;
        end
        default: phase <= DONE;
      endcase
    end
  end

  // Hand-off: word stays stable until the next instruction
  always_ff @(posedge shift_clock or posedge srst) begin
    if (srst) begin
      cmd <= '0;
      cmd_toggle <= 1'b0;
    end else if (select && issue) begin
      cmd.op <= hdr_end ? next_hdr[7:6] : hdr[7:6];
      cmd.addr <= hdr_end ? next_hdr[5:0] : hdr[5:0];
      cmd.data <= hdr_end ? 16'h0000 : {shreg[14:0], serial_data_in};
      cmd_toggle <= ~cmd_toggle;
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  a_read_dummy_zero: assert property (@(posedge shift_clock) disable iff (!select)
    hdr_end && next_kind == KIND_READ |=> read_drive && !read_bit)
    else $error("read did not begin with a zero bit");
  a_read_release: assert property (@(posedge shift_clock) disable iff (!select)
    $rose(read_drive) |-> ##17 !read_drive)
    else $error("read output not released after sixteen data bits");

endmodule

`default_nettype wire

/* hw/eeprom_pkg.sv */
// Types and instruction decoding shared by the EEPROM command port
`default_nettype none
`include "eeprom_regs.svh"

package eeprom_pkg;

  // Decoded instruction kinds
  typedef enum {KIND_READ, KIND_ENABLE, KIND_DISABLE, KIND_ERASE, KIND_WRITE, KIND_BULK_ERASE,
                KIND_BULK_FILL} cmd_kind_type;

  // Instruction handed from the link side to the core
  typedef struct packed {
    logic [1:0] op;
    logic [5:0] addr;
    logic [15:0] data;
  } cmd_type;

  // Opcode and address to instruction kind
  function automatic cmd_kind_type decode_kind(input logic [1:0] op, input logic [5:0] addr);
    case (op)
      `OP_READ: decode_kind = KIND_READ;
      `OP_WRITE: decode_kind = KIND_WRITE;
      `OP_ERASE: decode_kind = KIND_ERASE;
      default: begin
        case (addr[5:4])
          `SUB_ENABLE: decode_kind = KIND_ENABLE;
          `SUB_BULK_ERASE: decode_kind = KIND_BULK_ERASE;
          `SUB_BULK_FILL: decode_kind = KIND_BULK_FILL;
          default: decode_kind = KIND_DISABLE;
        endcase
      end
    endcase
  endfunction

endpackage

`default_nettype wire

/* hw/eeprom_port.sv */
// Serial EEPROM command port: array, programming control, status
`default_nettype none
`include "eeprom_regs.svh"

module eeprom_port
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLES = `PROG_TIME_US * `REF_CLK_MHZ,
  parameter int WORDS = `WORD_COUNT
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic shift_clock,
  input wire logic select,
  input wire logic serial_data_in,
  output logic data_out,
  output logic data_out_oe_n
);

  localparam int CS_LOW_CYC = (`CS_LOW_NS * `REF_CLK_MHZ + 999) / 1000;

  typedef enum {IDLE, BUSY} prog_state_type;

  logic [15:0] mem [WORDS];
  logic [15:0] rd_word;
  logic [5:0] rd_addr;
  logic read_drive;
  logic read_bit;
  cmd_type link_cmd;
  logic cmd_toggle;
  logic [1:0] sync_q;
  logic tog_s;
  logic sel_s;
  logic prev_tog;
  logic sel_prev;
  logic new_cmd;
  cmd_kind_type new_kind;
  logic new_prog;
  logic start;
  logic prog_en;
  prog_state_type state;
  logic [19:0] timer;
  cmd_type pend;
  cmd_kind_type pend_kind;
  logic commit;
  logic busy;
  logic [7:0] low_cnt;
  logic armed;
  logic show;

  // ----------------------------------------------------------------------------
  // Link side and crossings
  // ----------------------------------------------------------------------------
  eeprom_link u_eeprom_link (
    .shift_clock(shift_clock),
    .select(select),
    .serial_data_in(serial_data_in),
    .srst(srst),
    .rd_word(rd_word),
    .rd_addr(rd_addr),
    .read_drive(read_drive),
    .read_bit(read_bit),
    .cmd(link_cmd),
    .cmd_toggle(cmd_toggle)
  );

  sync2 #(.WIDTH(2)) u_sync2 (
    .clk(ref_clk),
    .srst(srst),
    .d({cmd_toggle, select}),
    .q(sync_q)
  );

  assign tog_s = sync_q[1];
  assign sel_s = sync_q[0];

  // Edge history of synchronised levels
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prev_tog <= 1'b0;
      sel_prev <= 1'b0;
    end else begin
      prev_tog <= tog_s;
      sel_prev <= sel_s;
    end
  end

  // New instruction decode
  assign new_cmd = tog_s ^ prev_tog;
  assign new_kind = decode_kind(link_cmd.op, link_cmd.addr);
  assign new_prog = new_kind == KIND_ERASE || new_kind == KIND_WRITE || new_kind == KIND_BULK_ERASE
                    || new_kind == KIND_BULK_FILL;
  assign start = new_cmd && new_prog && prog_en && state == IDLE;

  // ----------------------------------------------------------------------------
  // Programming enable
  // ----------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prog_en <= 1'b0;
    end else if (new_cmd && new_kind == KIND_ENABLE) begin
      prog_en <= 1'b1;
    end else if (new_cmd && new_kind == KIND_DISABLE) begin
      prog_en <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Self-timed programming cycle
  // ----------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= IDLE;
      timer <= '0;
      pend <= '0;
    end else begin
      case (state)
        IDLE: begin
          if (start) begin
            pend <= link_cmd;
            timer <= 20'(PROG_CYCLES - 1);
            state <= BUSY;
          end
        end
        BUSY: begin
          if (timer == '0) begin
            state <= IDLE;
          end else begin
            timer <= timer - 20'h00001;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  assign busy = state == BUSY;
  assign pend_kind = decode_kind(pend.op, pend.addr);
  assign commit = busy && timer == '0;

  // Array update at end of cycle; contents survive reset
  always_ff @(posedge ref_clk) begin
    if (commit) begin
      case (pend_kind)
        KIND_ERASE: mem[pend.addr] <= `ERASED_WORD;
        KIND_WRITE: mem[pend.addr] <= pend.data;
        KIND_BULK_ERASE: begin
          for (int i = 0; i < WORDS; i++) begin
            mem[i] <= `ERASED_WORD;
          end
        end
        KIND_BULK_FILL: begin
          for (int i = 0; i < WORDS; i++) begin
            mem[i] <= pend.data;
          end
        end
        default: mem[pend.addr] <= mem[pend.addr];
      endcase
    end
  end

  // Read port, addressed from the link side
  assign rd_word = mem[rd_addr];

  // ----------------------------------------------------------------------------
  // Ready/busy status
  // ----------------------------------------------------------------------------
  // Select-low time, saturating
  always_ff @(posedge ref_clk) begin
    if (srst || sel_s) begin
      low_cnt <= '0;
    end else if (low_cnt < 8'(CS_LOW_CYC)) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end

  // Status is owed after a started cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      armed <= 1'b0;
    end else if (start) begin
      armed <= 1'b1;
    end else if (!busy && !sel_s && !show) begin
      armed <= 1'b0;
    end
  end

  // Status shown from select rise until select falls
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      show <= 1'b0;
    end else if (sel_s && !sel_prev && armed && low_cnt >= 8'(CS_LOW_CYC)) begin
      show <= 1'b1;
    end else if (!sel_s) begin
      show <= 1'b0;
    end
  end

  // Output pin: read data first, else status, else floating
  assign data_out = read_drive ? read_bit : !busy;
  assign data_out_oe_n = !(read_drive || show);

  // ----------------------------------------------------------------------------
  // Assertion helpers
  // ----------------------------------------------------------------------------
  // Cycles spent busy in the running programming cycle
  logic [19:0] busy_len;

  always_ff @(posedge ref_clk) begin
    if (srst || !busy) begin
      busy_len <= '0;
    end else begin
      busy_len <= busy_len + 20'h00001;
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  // Enable state, array contents and status
  a_power_up_off: assert property (@(posedge ref_clk) srst |=> !prog_en)
    else $error("programming enabled after reset");
  a_enable_cmd: assert property (@(posedge ref_clk) disable iff (srst)
    new_cmd && new_kind == KIND_ENABLE |=> prog_en)
    else $error("enable instruction did not enable");
  a_disable_cmd: assert property (@(posedge ref_clk) disable iff (srst)
    new_cmd && new_kind == KIND_DISABLE |=> !prog_en)
    else $error("disable instruction did not disable");
  a_enable_holds: assert property (@(posedge ref_clk) disable iff (srst)
    prog_en && !(new_cmd && new_kind == KIND_DISABLE) |=> prog_en)
    else $error("enable dropped without disable");
  a_locked_refuse: assert property (@(posedge ref_clk) disable iff (srst)
    new_cmd && new_prog && !prog_en && !busy |=> !busy)
    else $error("programming started while disabled");
  a_erase_start: assert property (@(posedge ref_clk) disable iff (srst)
    new_cmd && new_kind == KIND_ERASE && prog_en && !busy |=> busy && timer == 20'(PROG_CYCLES - 1))
    else $error("word erase did not start its cycle");
  a_erase_value: assert property (@(posedge ref_clk) disable iff (srst)
    commit && pend_kind == KIND_ERASE |=> mem[pend.addr] == `ERASED_WORD)
    else $error("erased word not all ones");
  a_write_value: assert property (@(posedge ref_clk) disable iff (srst)
    commit && pend_kind == KIND_WRITE |=> mem[pend.addr] == pend.data)
    else $error("written word does not match data");
  a_bulk_erase: assert property (@(posedge ref_clk) disable iff (srst)
    commit && pend_kind == KIND_BULK_ERASE |=> mem[0] == `ERASED_WORD && mem[WORDS-1] == `ERASED_WORD)
    else $error("bulk erase left a word not all ones");
  a_bulk_fill: assert property (@(posedge ref_clk) disable iff (srst)
    commit && pend_kind == KIND_BULK_FILL |=> mem[0] == pend.data && mem[WORDS-1] == pend.data)
    else $error("bulk fill left a word unfilled");
  a_status_busy: assert property (@(posedge ref_clk) disable iff (srst)
    show && busy && !read_drive |-> !data_out && !data_out_oe_n)
    else $error("status not zero while busy");
  a_status_ready: assert property (@(posedge ref_clk) disable iff (srst)
    show && !busy && !read_drive |-> data_out && !data_out_oe_n)
    else $error("status not one when ready");
  a_late_no_status: assert property (@(posedge ref_clk) disable iff (srst)
    armed && !busy && !sel_s && !show |=> !armed ##1 !show)
    else $error("status owed after cycle ended with select low");
  a_status_poll: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(sel_s) && armed && low_cnt >= 8'(CS_LOW_CYC) |=> show)
    else $error("poll after select low did not show status");
  a_float_low: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(sel_s) |=> !show)
    else $error("status kept after select fell");

  // Cycle length, hand-off and pin ownership
  a_idle_after_reset: assert property (@(posedge ref_clk)
    srst |=> !busy && !armed && !show)
    else $error("cycle or status left over after reset");
  a_start_busy: assert property (@(posedge ref_clk) disable iff (srst)
    start |=> busy && armed)
    else $error("accepted instruction did not start a cycle");
  a_timer_count: assert property (@(posedge ref_clk) disable iff (srst)
    busy && timer != '0 |=> busy && timer == $past(timer) - 20'h00001)
    else $error("cycle timer did not count down by one");
  a_pend_steady: assert property (@(posedge ref_clk) disable iff (srst)
    busy |=> $stable(pend))
    else $error("pending instruction changed during its cycle");
  a_cycle_length: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(busy) |-> busy_len == 20'(PROG_CYCLES))
    else $error("programming cycle had the wrong length");
  a_ready_after: assert property (@(posedge ref_clk) disable iff (srst)
    commit |=> !busy)
    else $error("still busy after the array was updated");
  a_unarmed_quiet: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(sel_s) && !armed |=> !show)
    else $error("status shown with no cycle owed");
  a_float_after_fall: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(sel_s) |=> data_out_oe_n)
    else $error("output still driven after select fell");
  a_read_owns_pin: assert property (@(posedge ref_clk) disable iff (srst)
    read_drive |-> !data_out_oe_n && data_out == read_bit)
    else $error("read bit not on the output pin");

  c_enable: cover property (@(posedge ref_clk) disable iff (srst) new_cmd && new_kind == KIND_ENABLE);
  c_write_done: cover property (@(posedge ref_clk) disable iff (srst) commit && pend_kind == KIND_WRITE);
  c_status_ready: cover property (@(posedge ref_clk) disable iff (srst) show && !busy);
  c_read: cover property (@(posedge ref_clk) disable iff (srst) $rose(read_drive));
  c_refused: cover property (@(posedge ref_clk) disable iff (srst) new_cmd && new_prog && !prog_en);

endmodule

`default_nettype wire

/* hw/eeprom_regs.svh */
// Constants for the three-wire serial EEPROM command port
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

// ----------------------------------------------------------------------------
// Instruction encoding
// ----------------------------------------------------------------------------
`define OP_SPECIAL 2'h0
`define OP_WRITE 2'h1
`define OP_READ 2'h2
`define OP_ERASE 2'h3
`define SUB_DISABLE 2'h0
`define SUB_BULK_FILL 2'h1
`define SUB_BULK_ERASE 2'h2
`define SUB_ENABLE 2'h3

// ----------------------------------------------------------------------------
// Frame geometry and array shape
// ----------------------------------------------------------------------------
`define HDR_LAST 5'h07
`define WORD_LAST 5'h0f
`define WORD_BITS 5'h10
`define WORD_COUNT 64
`define ERASED_WORD 16'hffff

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define REF_CLK_MHZ 100
`define PROG_TIME_US 5000
`define CS_LOW_NS 250

`endif

/* hw/sync2.sv */
// Two-flop level synchroniser
`default_nettype none

module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

`default_nettype wire
